// File: verilog/sdp_top.v
// sdp_top.v: data path of the dual mode serial port (UART and 3-wire).
// Assumes a CPU memory port on CLK_IN; pins arrive asynchronously.
//
// Overview of operation
// - writing transmit register starts a transmission
// - seven-bit characters send bits 0 to 6
// - transmit register resets to ones, write only
// - one address: read buffer, write transmit
// - shift register assembles character, copies to buffer
// - seven-bit receive leaves buffer MSB zero
// - buffer readable as byte, never writable
// - receive buffer undefined after reset
// - transmitter adds start, parity and stop bits
// - receiver flags parity and other errors
// - sync control resets zero, bit or byte writable
// - sync enable bit gates 3-wire operation
// - slave select low enables when used
// - data phase picks output clock edge
// - first-bit select picks MSB or LSB
// - clock source: pin or baud generator
// - clock polarity sets idle clock level
// - 3-wire shifts eight bits both ways
// - UART transmit and receive run concurrently
`timescale 1ns/100ps
`default_nettype none
`include "sdp_defs.vh"

module sdp_top
(
  input wire CLK_IN,
  input wire RESET_N_IN,
  input wire [15:0] ADDR_IN,
  input wire WR_IN,
  input wire RD_IN,
  input wire [7:0] WDATA_IN,
  input wire BIT_WR_IN,
  input wire [2:0] BIT_SEL_IN,
  input wire BIT_VAL_IN,
  input wire RXD_SI_IN,
  input wire SCK_IN,
  input wire SLAVE_SELECT_N_IN,
  output reg [7:0] RDATA_OUT,
  output reg TXD_OUT,
  output reg SO_OUT,
  output reg SCK_OUT,
  output reg SCK_OE_N_OUT,
  output reg DONE_OUT
);

  localparam TX_IDLE = 3'd0;
  localparam TX_START = 3'd1;
  localparam TX_DATA = 3'd2;
  localparam TX_PAR = 3'd3;
  localparam TX_STOP = 3'd4;
  localparam RX_IDLE = 3'd0;
  localparam RX_START = 3'd1;
  localparam RX_DATA = 3'd2;
  localparam RX_PAR = 3'd3;
  localparam RX_STOP = 3'd4;

  reg [7:0] sync_mode_control_reg;
  reg [7:0] async_mode_reg;
  reg [2:0] async_status_reg;
  reg [7:0] baud_divider_reg;
  reg [7:0] transmit_shift_reg;
  reg [7:0] receive_shift_reg;
  reg [7:0] receive_buffer_reg;
  reg rx_full_reg;
  reg [7:0] sync_mode_control_next;
  reg [7:0] async_mode_next;
  wire [2:0] pins;
  wire tick;

  // ----------------------------------------------------------------------
  // pin synchronisers and baud divider
  // ----------------------------------------------------------------------
  sdp_sync #(.WIDTH(3)) u_sync
  (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .pins_in({SLAVE_SELECT_N_IN, SCK_IN, RXD_SI_IN}),
    .levels_out(pins)
  );
  sdp_baud u_baud
  (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .divisor_in(baud_divider_reg),
    .tick_out(tick)
  );

  // ----------------------------------------------------------------------
  // CPU access decode
  // ----------------------------------------------------------------------
  wire at_data = ADDR_IN == `SDP_ADDR_DATA;
  wire at_sc = ADDR_IN == `SDP_ADDR_SYNC_CTRL;
  wire at_am = ADDR_IN == `SDP_ADDR_ASYNC_MODE;
  wire at_st = ADDR_IN == `SDP_ADDR_ASYNC_STAT;
  wire wr_data = WR_IN && at_data;
  wire sync_en = sync_mode_control_reg[`SDP_SC_ENABLE];
  wire dap = sync_mode_control_reg[`SDP_SC_PHASE];
  wire lsb_first = sync_mode_control_reg[`SDP_SC_FIRST];
  wire int_clk = sync_mode_control_reg[`SDP_SC_CLK_SRC];
  wire ckp = sync_mode_control_reg[`SDP_SC_POLARITY];
  wire len8 = async_mode_reg[`SDP_AM_LEN8];
  wire [1:0] par_mode = async_mode_reg[`SDP_AM_PAR_HI:`SDP_AM_PAR_LO];

  // byte write or single-bit write merged into one next value
  function [7:0] merge;
    input [7:0] old;
    input byte_wr;
    input bit_wr;
    input [7:0] mask;
    reg [7:0] val;
    begin
      val = old;
      if (byte_wr)
        val = WDATA_IN;
      else if (bit_wr)
        val[BIT_SEL_IN] = BIT_VAL_IN;
      merge = val & mask;
    end
  endfunction

  // control registers take byte or bit writes; sync control bits 4,5 and async mode bits 0,1 always stay zero
  always @*
  begin
    sync_mode_control_next = merge(sync_mode_control_reg, WR_IN && at_sc, BIT_WR_IN && at_sc, `SDP_SC_MASK);
    async_mode_next = merge(async_mode_reg, WR_IN && at_am, BIT_WR_IN && at_am, `SDP_AM_MASK);
  end

  // ----------------------------------------------------------------------
  // 3-wire engine
  // ----------------------------------------------------------------------
  reg sync_busy_reg;
  reg [7:0] sync_sr_reg;
  reg [3:0] samp_cnt_reg;
  reg [3:0] edge_cnt_reg;
  reg sck_prev_reg;
  reg sync_done_reg;
  wire comm_ok = !sync_mode_control_reg[`SDP_SC_SS_USE] || !pins[2];
  wire run = sync_en && sync_busy_reg && comm_ok;
  wire go_rise = int_clk ? (tick && !SCK_OUT) : (pins[1] && !sck_prev_reg);
  wire go_fall = int_clk ? (tick && SCK_OUT) : (!pins[1] && sck_prev_reg);
  wire samp_edge = run && (dap ? go_fall : go_rise);
  wire out_edge = run && (dap ? go_rise : go_fall);
  wire [7:0] sync_shifted = lsb_first ? {pins[0], sync_sr_reg[7:1]} : {sync_sr_reg[6:0], pins[0]};
  wire samp_last = samp_edge && samp_cnt_reg[2:0] == `SDP_BITS_LAST;

  // shifts eight bits out and in at once; a write mid-transfer is the caller's fault
  always @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      sync_busy_reg <= 1'b0;
      sync_sr_reg <= 8'h00;
      samp_cnt_reg <= 4'h0;
      edge_cnt_reg <= 4'h0;
      sck_prev_reg <= 1'b1;
      sync_done_reg <= 1'b0;
      SO_OUT <= 1'b1;
      SCK_OUT <= 1'b1;
      SCK_OE_N_OUT <= 1'b1;
    end
    else
    begin
      sck_prev_reg <= pins[1];
      sync_done_reg <= samp_last;
      SCK_OE_N_OUT <= !(sync_en && int_clk);
      if (!sync_en)
      begin
        sync_busy_reg <= 1'b0;
      end
      else if (wr_data)
      begin
        sync_busy_reg <= 1'b1;
        sync_sr_reg <= WDATA_IN;
        samp_cnt_reg <= 4'h0;
        edge_cnt_reg <= 4'h0;
        SO_OUT <= lsb_first ? WDATA_IN[0] : WDATA_IN[7];
      end
      else
      begin
        if (samp_edge)
        begin
          sync_sr_reg <= sync_shifted;
          samp_cnt_reg <= samp_cnt_reg + 4'h1;
          if (samp_last && !int_clk)
            sync_busy_reg <= 1'b0;
        end
        if (out_edge && samp_cnt_reg != 4'h0)
          SO_OUT <= lsb_first ? sync_sr_reg[0] : sync_sr_reg[7];
        // internal clock runs sixteen edges so the line ends idle
        if (run && int_clk && tick)
        begin
          edge_cnt_reg <= edge_cnt_reg + 4'h1;
          if (edge_cnt_reg == `SDP_EDGES_LAST)
            sync_busy_reg <= 1'b0;
        end
      end
      if (!(run && int_clk))
        SCK_OUT <= !ckp;
      else if (tick)
        SCK_OUT <= !SCK_OUT;
    end
  end

  // ----------------------------------------------------------------------
  // UART transmitter
  // ----------------------------------------------------------------------
  reg [2:0] tx_state_reg;
  reg [3:0] tx_tick_reg;
  reg [2:0] tx_bit_reg;
  reg [7:0] tx_sr_reg;
  reg tx_stop2_reg;
  wire tx_bit_end = tick && tx_tick_reg == `SDP_OVS_LAST;
  // odd parity makes the total odd, zero mode sends a fixed 0
  wire [7:0] tx_masked = len8 ? transmit_shift_reg : {1'b0, transmit_shift_reg[6:0]};
  wire tx_parity_bit = par_mode == 2'b10 ? ~^tx_masked : (par_mode == 2'b11 ? ^tx_masked : 1'b0);
  reg tx_par_hold_reg;

  // framing follows the async mode register sampled at the start; parity on or off is read live after the last data bit
  always @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      tx_state_reg <= TX_IDLE;
      tx_tick_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_sr_reg <= 8'hFF;
      tx_stop2_reg <= 1'b0;
      tx_par_hold_reg <= 1'b0;
      TXD_OUT <= 1'b1;
    end
    else
    begin
      if (tick)
        tx_tick_reg <= tx_tick_reg + 4'h1;
      case (tx_state_reg)
        TX_IDLE:
        begin
          TXD_OUT <= 1'b1;
          tx_tick_reg <= 4'h0;
          if (wr_data && !sync_en && async_mode_reg[`SDP_AM_TX_EN])
            tx_state_reg <= TX_START;
        end
        TX_START:
        begin
          TXD_OUT <= 1'b0;
          tx_sr_reg <= transmit_shift_reg;
          tx_par_hold_reg <= tx_parity_bit;
          tx_stop2_reg <= async_mode_reg[`SDP_AM_STOP2];
          tx_bit_reg <= len8 ? 3'h7 : 3'h6;
          if (tx_bit_end)
            tx_state_reg <= TX_DATA;
        end
        TX_DATA:
        begin
          TXD_OUT <= tx_sr_reg[0];
          if (tx_bit_end)
          begin
            tx_sr_reg <= {1'b1, tx_sr_reg[7:1]};
            tx_bit_reg <= tx_bit_reg - 3'h1;
            if (tx_bit_reg == 3'h0)
              tx_state_reg <= par_mode == 2'b00 ? TX_STOP : TX_PAR;
          end
        end
        TX_PAR:
        begin
          TXD_OUT <= tx_par_hold_reg;
          if (tx_bit_end)
            tx_state_reg <= TX_STOP;
        end
        TX_STOP:
        begin
          TXD_OUT <= 1'b1;
          if (tx_bit_end)
          begin
            tx_stop2_reg <= 1'b0;
            if (!tx_stop2_reg)
              tx_state_reg <= TX_IDLE;
          end
        end
        default:
          tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // UART receiver, independent of the transmitter
  // ----------------------------------------------------------------------
  reg [2:0] rx_state_reg;
  reg [3:0] rx_tick_reg;
  reg [2:0] rx_bit_reg;
  reg rx_par_reg;
  reg rx_perr_reg;
  reg [2:0] st_set;
  reg rx_load;
  wire rx_mid = tick && rx_tick_reg == `SDP_OVS_LAST;

  always @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      rx_state_reg <= RX_IDLE;
      rx_tick_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_par_reg <= 1'b0;
      rx_perr_reg <= 1'b0;
      receive_shift_reg <= 8'h00;
    end
    else
    begin
      if (tick)
        rx_tick_reg <= rx_tick_reg + 4'h1;
      case (rx_state_reg)
        RX_IDLE:
        begin
          rx_tick_reg <= 4'h0;
          rx_par_reg <= 1'b0;
          rx_bit_reg <= len8 ? 3'h7 : 3'h6;
          if (!pins[0] && !sync_en && async_mode_reg[`SDP_AM_RX_EN])
            rx_state_reg <= RX_START;
        end
        RX_START:
        begin
          // recheck at mid bit so a glitch is not taken as a start
          if (tick && rx_tick_reg == `SDP_OVS_MID)
          begin
            rx_tick_reg <= 4'h0;
            rx_state_reg <= pins[0] ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (rx_mid)
          begin
            receive_shift_reg <= {pins[0], receive_shift_reg[7:1]};
            rx_par_reg <= rx_par_reg ^ pins[0];
            rx_bit_reg <= rx_bit_reg - 3'h1;
            if (rx_bit_reg == 3'h0)
              rx_state_reg <= par_mode == 2'b00 ? RX_STOP : RX_PAR;
          end
        end
        RX_PAR:
        begin
          if (rx_mid)
          begin
            // odd mode errs on an even total of ones, even mode on an odd total
            rx_perr_reg <= par_mode[1] && ((rx_par_reg ^ pins[0]) == par_mode[0]);
            rx_state_reg <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          if (rx_mid)
            rx_state_reg <= RX_IDLE;
        end
        default:
          rx_state_reg <= RX_IDLE;
      endcase
      if (rx_state_reg == RX_IDLE)
        rx_perr_reg <= 1'b0;
    end
  end

  // error events of a finished character, with overrun from the full flag
  always @*
  begin
    rx_load = rx_state_reg == RX_STOP && rx_mid;
    st_set = 3'h0;
    st_set[`SDP_ST_PARITY] = rx_load && rx_perr_reg;
    st_set[`SDP_ST_FRAMING] = rx_load && !pins[0];
    st_set[`SDP_ST_OVERRUN] = (rx_load || sync_done_reg) && rx_full_reg;
  end

  // ----------------------------------------------------------------------
  // registers, buffer and read port
  // ----------------------------------------------------------------------
  // buffer has no reset
  always @(posedge CLK_IN)
  begin
    if (rx_load)
      receive_buffer_reg <= len8 ? receive_shift_reg : {1'b0, receive_shift_reg[7:1]};
    else if (sync_done_reg)
      receive_buffer_reg <= sync_sr_reg;
  end

  // flags set by hardware win over a clearing read in the same cycle
  always @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      sync_mode_control_reg <= `SDP_SC_RESET;
      async_mode_reg <= `SDP_AM_RESET;
      baud_divider_reg <= `SDP_BAUD_RESET;
      transmit_shift_reg <= `SDP_TX_RESET;
      async_status_reg <= `SDP_ST_RESET;
      rx_full_reg <= 1'b0;
      RDATA_OUT <= 8'h00;
      DONE_OUT <= 1'b0;
    end
    else
    begin
      sync_mode_control_reg <= sync_mode_control_next;
      async_mode_reg <= async_mode_next;
      if (WR_IN && ADDR_IN == `SDP_ADDR_BAUD)
        baud_divider_reg <= WDATA_IN;
      if (wr_data)
        transmit_shift_reg <= WDATA_IN;
      async_status_reg <= (async_status_reg & {3{!(RD_IN && at_st)}}) | st_set;
      rx_full_reg <= (rx_full_reg && !(RD_IN && at_data)) || rx_load || sync_done_reg;
      DONE_OUT <= rx_load || sync_done_reg;
      if (RD_IN)
      begin
        if (at_data)
          RDATA_OUT <= receive_buffer_reg;
        else if (at_sc)
          RDATA_OUT <= sync_mode_control_reg;
        else if (at_am)
          RDATA_OUT <= async_mode_reg;
        else if (at_st)
          RDATA_OUT <= {5'h00, async_status_reg};
        else if (ADDR_IN == `SDP_ADDR_BAUD)
          RDATA_OUT <= baud_divider_reg;
        else
          RDATA_OUT <= 8'h00;
      end
    end
  end

endmodule // sdp_top
`default_nettype wire

// File: verilog/sdp_defs.vh
// sdp_defs.vh: addresses, field positions, reset values and counts of the
// dual mode serial port. Assumes the includer uses 16-bit CPU data addresses.
`ifndef SDP_DEFS_VH
`define SDP_DEFS_VH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define SDP_ADDR_ASYNC_MODE 16'hFF70
`define SDP_ADDR_DATA 16'hFF71
`define SDP_ADDR_SYNC_CTRL 16'hFF72
`define SDP_ADDR_ASYNC_STAT 16'hFF73
`define SDP_ADDR_BAUD 16'hFF74

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SDP_SC_ENABLE 7
`define SDP_SC_SS_USE 6
`define SDP_SC_PHASE 3
`define SDP_SC_FIRST 2
`define SDP_SC_CLK_SRC 1
`define SDP_SC_POLARITY 0
`define SDP_AM_TX_EN 7
`define SDP_AM_RX_EN 6
`define SDP_AM_PAR_HI 5
`define SDP_AM_PAR_LO 4
`define SDP_AM_LEN8 3
`define SDP_AM_STOP2 2
`define SDP_ST_PARITY 2
`define SDP_ST_FRAMING 1
`define SDP_ST_OVERRUN 0

// ----------------------------------------------------------------------
// writable masks and reset values
// ----------------------------------------------------------------------
`define SDP_SC_MASK 8'hCF
`define SDP_AM_MASK 8'hFC
`define SDP_SC_RESET 8'h00
`define SDP_AM_RESET 8'h00
`define SDP_TX_RESET 8'hFF
`define SDP_BAUD_RESET 8'h0F
`define SDP_ST_RESET 3'h0

// ----------------------------------------------------------------------
// timing counts, in baud ticks and bits
// ----------------------------------------------------------------------
`define SDP_OVS_LAST 4'hF
`define SDP_OVS_MID 4'h7
`define SDP_EDGES_LAST 4'hF
`define SDP_BITS_LAST 3'h7

`endif

// File: verilog/sdp_sync.v
// sdp_sync.v: two flip-flop synchroniser for a group of pin levels.
// Assumes the pins are slow levels with no relation to CLK_IN.
`timescale 1ns/100ps
`default_nettype none

module sdp_sync
#(
  parameter WIDTH = 3
)
(
  input wire clk_in,
  input wire reset_n_in,
  input wire [WIDTH-1:0] pins_in,
  output wire [WIDTH-1:0] levels_out
);

  // ----------------------------------------------------------------------
  // per-bit stages
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg first_reg;
      reg second_reg;
      // first stage feeds only the second; resets idle high like the pins
      always @(posedge clk_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
        begin
          first_reg <= 1'b1;
          second_reg <= 1'b1;
        end
        else
        begin
          first_reg <= pins_in[i];
          second_reg <= first_reg;
        end
      end
      assign levels_out[i] = second_reg;
    end
  endgenerate

endmodule // sdp_sync
`default_nettype wire

// File: verilog/sdp_baud.v
// sdp_baud.v: baud tick divider, one-cycle enable every divisor+1 clocks.
// Assumes the divisor is static while a transfer runs.
`timescale 1ns/100ps
`default_nettype none

module sdp_baud
(
  input wire clk_in,
  input wire reset_n_in,
  input wire [7:0] divisor_in,
  output reg tick_out
);

  reg [7:0] count_reg;

  // ----------------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------------
  // count up to the divisor, then pulse and restart
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      count_reg <= 8'h00;
      tick_out <= 1'b0;
    end
    else if (count_reg >= divisor_in)
    begin
      count_reg <= 8'h00;
      tick_out <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 8'h01;
      tick_out <= 1'b0;
    end
  end

endmodule // sdp_baud
`default_nettype wire

// File: verif/sdp_top_properties.sv
// sdp_top_properties.sv: port checks of the serial port data path.
// Assumes transmit writes never land on a running frame.
`timescale 1ns/100ps
`default_nettype none
`include "sdp_defs.vh"

module sdp_chk
(
  input wire CLK_IN,
  input wire RESET_N_IN,
  input wire [15:0] ADDR_IN,
  input wire WR_IN,
  input wire RD_IN,
  input wire [7:0] WDATA_IN,
  input wire BIT_WR_IN,
  input wire [2:0] BIT_SEL_IN,
  input wire BIT_VAL_IN,
  input wire [7:0] RDATA_OUT,
  input wire TXD_OUT,
  input wire SO_OUT,
  input wire SCK_OUT,
  input wire SCK_OE_N_OUT,
  input wire DONE_OUT
);
  // ----------------------------------------------------------------------
  // shadow of the control bytes
  // ----------------------------------------------------------------------
  reg [7:0] sc_reg;
  reg [7:0] am_reg;
  wire sc_wr = (WR_IN || BIT_WR_IN) && ADDR_IN == `SDP_ADDR_SYNC_CTRL;
  wire dat_wr = WR_IN && ADDR_IN == `SDP_ADDR_DATA;
  wire unmapped = ADDR_IN < `SDP_ADDR_ASYNC_MODE || ADDR_IN > `SDP_ADDR_BAUD;
  wire first_bit = sc_reg[2] ? WDATA_IN[0] : WDATA_IN[7];
  // byte write wins over a bit write in the same cycle
  always @(posedge CLK_IN or negedge RESET_N_IN)
    if (!RESET_N_IN)
      {sc_reg, am_reg} <= 16'h0000;
    else if (WR_IN)
    begin
      if (ADDR_IN == `SDP_ADDR_SYNC_CTRL) sc_reg <= WDATA_IN & `SDP_SC_MASK;
      if (ADDR_IN == `SDP_ADDR_ASYNC_MODE) am_reg <= WDATA_IN & `SDP_AM_MASK;
    end
    else if (BIT_WR_IN)
    begin
      if (sc_wr)
        sc_reg <= (sc_reg & ~(8'h01 << BIT_SEL_IN) | ({7'h00, BIT_VAL_IN} << BIT_SEL_IN)) & `SDP_SC_MASK;
      if (ADDR_IN == `SDP_ADDR_ASYNC_MODE)
        am_reg <= (am_reg & ~(8'h01 << BIT_SEL_IN) | ({7'h00, BIT_VAL_IN} << BIT_SEL_IN)) & `SDP_AM_MASK;
    end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  property p_rd_unmapped; RD_IN && unmapped |=> RDATA_OUT == 8'h00; endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
  property p_rd_hold; !RD_IN |=> $stable(RDATA_OUT); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_sc_read; RD_IN && ADDR_IN == `SDP_ADDR_SYNC_CTRL |=> RDATA_OUT == $past(sc_reg); endproperty
  a_sc_read: assert property (p_sc_read) else $error("sync control readback");
  // pin driven only for internal clock
  property p_oe; (!sc_wr)[*3] |=> SCK_OE_N_OUT == !(sc_reg[7] && sc_reg[1]); endproperty
  a_oe: assert property (p_oe) else $error("clock drive enable");
  // disabled clock rests at idle level
  property p_idle; (!sc_wr && !sc_reg[7])[*3] |=> SCK_OUT == !sc_reg[0]; endproperty
  a_idle: assert property (p_idle) else $error("clock idle level");
  property p_tx_go; dat_wr && am_reg[7] && !sc_reg[7] |-> ##2 !TXD_OUT; endproperty
  a_tx_go: assert property (p_tx_go) else $error("no start bit");
  // first bit out follows the order bit
  property p_so_first; dat_wr && sc_reg[7] && !sc_reg[6] |=> SO_OUT == $past(first_bit); endproperty
  a_so_first: assert property (p_so_first) else $error("first bit");
  // buffer load strobe is one cycle
  property p_done; DONE_OUT |=> !DONE_OUT; endproperty
  a_done: assert property (p_done) else $error("done too long");
  c_done: cover property (DONE_OUT);
  c_drive: cover property (!SCK_OE_N_OUT);
  c_start: cover property (!TXD_OUT);
endmodule // sdp_chk

bind sdp_top sdp_chk i_sdp_chk (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .ADDR_IN(ADDR_IN), .WR_IN(WR_IN),
  .RD_IN(RD_IN), .WDATA_IN(WDATA_IN), .BIT_WR_IN(BIT_WR_IN), .BIT_SEL_IN(BIT_SEL_IN), .BIT_VAL_IN(BIT_VAL_IN),
  .RDATA_OUT(RDATA_OUT), .TXD_OUT(TXD_OUT), .SO_OUT(SO_OUT), .SCK_OUT(SCK_OUT), .SCK_OE_N_OUT(SCK_OE_N_OUT),
  .DONE_OUT(DONE_OUT));
`default_nettype wire

// File: verif/sdp_peer.sv
// sdp_peer.sv: remote UART and 3-wire slave on the serial pins.
// Assumes one baud tick per clock in UART mode.
`timescale 1ns/100ps
`default_nettype none

module sdp_peer
#(
  parameter BIT_CLKS = 16
)
(
  input wire clk_in,
  input wire txd_in,
  input wire so_in,
  input wire sck_in,
  input wire sync_in,
  output wire rxd_out
);
  // ----------------------------------------------------------------------
  // line model
  // ----------------------------------------------------------------------
  reg uart_line = 1'b1;
  reg [7:0] tx_sh = 8'h00;
  reg [7:0] rx_sh = 8'h00;
  reg [9:0] frame = 10'h000;
  integer rises = 0;
  integer frames = 0;
  integer i;
  assign rxd_out = sync_in ? tx_sh[7] : uart_line;
  // caller builds start, data, parity and stops, sent lsb first
  task send(input [11:0] f, input integer n);
    integer k;
    begin
      for (k = 0; k < n; k++)
      begin
        uart_line = f[k];
        repeat (BIT_CLKS) @(posedge clk_in);
        #1;
      end
      uart_line = 1'b1;
    end
  endtask
  task load(input [7:0] b);
    begin
      tx_sh = b;
      rises = 0;
    end
  endtask
  // mid-bit capture of ten bits after the start bit
  initial
    forever
    begin
      @(negedge txd_in);
      repeat (BIT_CLKS / 2) @(posedge clk_in);
      for (i = 0; i < 10; i++)
      begin
        repeat (BIT_CLKS) @(posedge clk_in);
        frame[i] = txd_in;
      end
      frames++;
    end
  // sample on rise, next bit after a fall
  always @(posedge sck_in)
  begin
    rx_sh <= {rx_sh[6:0], so_in};
    rises <= rises + 1;
  end
  // the first fall precedes any sample, so it must not shift
  always @(negedge sck_in)
    if (rises > 0) tx_sh <= {tx_sh[6:0], ~tx_sh[7]};
endmodule // sdp_peer
`default_nettype wire

// File: verif/sdp_top_tb_top.sv
// sdp_top_tb_top.sv: register, UART and 3-wire tests of the serial port.
// Assumes sdp_peer on the pins; the serial clock pin loops back.
`timescale 1ns/100ps
`default_nettype none
`include "sdp_defs.vh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; $display("mismatch %s %h %h", n, e, s); end end

module sdp_top_tb_top;
  // ----------------------------------------------------------------------
  // bench
  // ----------------------------------------------------------------------
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [15:0] addr = 16'h0000;
  reg [7:0] wdata = 8'h00;
  reg [2:0] bsel = 3'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg bwr = 1'b0;
  reg bval = 1'b0;
  reg ss_n = 1'b0;
  reg sm = 1'b0;
  reg [7:0] rv;
  wire [7:0] rdata;
  wire txd, so, sck, oe_n, done, rxd;
  integer err_total = 0;
  integer num_checks = 0;
  integer dones = 0;
  integer cyc = 0;
  integer d0, f0, m;
  always #5 clk = ~clk;
  sdp_top i_sdp_top (.CLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WR_IN(wr), .RD_IN(rd),
    .WDATA_IN(wdata), .BIT_WR_IN(bwr), .BIT_SEL_IN(bsel), .BIT_VAL_IN(bval), .RXD_SI_IN(rxd),
    .SCK_IN(sck), .SLAVE_SELECT_N_IN(ss_n), .RDATA_OUT(rdata), .TXD_OUT(txd), .SO_OUT(so),
    .SCK_OUT(sck), .SCK_OE_N_OUT(oe_n), .DONE_OUT(done));
  sdp_peer i_sdp_peer (.clk_in(clk), .txd_in(txd), .so_in(so), .sck_in(sck), .sync_in(sm), .rxd_out(rxd));
  // kind 0 byte write, 1 read into rv, 2 bit write (d[2:0] bit, d[3] value)
  task acc(input integer k, input [15:0] a, input [7:0] d);
    begin
      @(posedge clk);
      #1;
      {addr, wdata, bsel, bval} = {a, d, d[2:0], d[3]};
      {wr, rd, bwr} = {k == 0, k == 1, k == 2};
      @(posedge clk);
      #1;
      {wr, rd, bwr} = 3'b000;
      @(posedge clk);
      #1;
      rv = rdata;
    end
  endtask
  // bounded wait on the done count (s=0) or the peer frame count (s=1)
  task wait_cnt(input s, input integer n);
    integer k;
    begin
      for (k = 0; k < 3000 && (s ? i_sdp_peer.frames : dones) <= n; k++)
        @(posedge clk);
      `CHK("wait", 1'b1, k < 3000)
      #1;
    end
  endtask
  task results;
    begin
      if (err_total == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  always @(posedge clk)
    if (done === 1'b1) dones <= dones + 1;
  // a hang costs a mismatch
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      results;
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // control register reset, byte and bit writes
    acc(1, `SDP_ADDR_SYNC_CTRL, 8'h00);
    `CHK("sc rst", 8'h00, rv)
    `CHK("txd", 1'b1, txd)
    `CHK("oe", 1'b1, oe_n)
    acc(0, `SDP_ADDR_SYNC_CTRL, 8'hCF);
    acc(2, `SDP_ADDR_SYNC_CTRL, 8'h07);
    acc(1, `SDP_ADDR_SYNC_CTRL, 8'h00);
    `CHK("sc bits", 8'h4F, rv)
    acc(0, `SDP_ADDR_SYNC_CTRL, 8'h00);
    acc(1, 16'h1234, 8'h00);
    `CHK("unmapped", 8'h00, rv)
    // full duplex: even parity out, bad parity in
    acc(0, `SDP_ADDR_BAUD, 8'h00);
    acc(0, `SDP_ADDR_ASYNC_MODE, 8'hF8);
    {d0, f0} = {dones, i_sdp_peer.frames};
    fork
      acc(0, `SDP_ADDR_DATA, 8'hA5);
      i_sdp_peer.send({1'b1, 1'b1, 8'hA5, 1'b0}, 11);
    join
    wait_cnt(1, f0);
    wait_cnt(0, d0);
    `CHK("tx frame", 10'h2A5, i_sdp_peer.frame)
    acc(1, `SDP_ADDR_DATA, 8'h00);
    `CHK("rx", 8'hA5, rv)
    acc(1, `SDP_ADDR_ASYNC_STAT, 8'h00);
    `CHK("parity", 8'h04, rv)
    // seven-bit characters both ways; read shows buffer, not write
    acc(0, `SDP_ADDR_ASYNC_MODE, 8'hC0);
    {d0, f0} = {dones, i_sdp_peer.frames};
    fork
      acc(0, `SDP_ADDR_DATA, 8'h55);
      i_sdp_peer.send({1'b1, 7'h6A, 1'b0}, 9);
    join
    wait_cnt(1, f0);
    wait_cnt(0, d0);
    `CHK("tx7", 10'h3D5, i_sdp_peer.frame)
    acc(1, `SDP_ADDR_DATA, 8'h00);
    `CHK("rx7", 8'h6A, rv)
    // 3-wire, internal clock, msb then lsb first
    acc(0, `SDP_ADDR_ASYNC_MODE, 8'h00);
    acc(0, `SDP_ADDR_BAUD, 8'h07);
    sm = 1'b1;
    for (m = 0; m < 2; m++)
    begin
      acc(0, `SDP_ADDR_SYNC_CTRL, m ? 8'h86 : 8'h82);
      `CHK("idle", 1'b1, sck)
      `CHK("drive", 1'b0, oe_n)
      i_sdp_peer.load(8'h12);
      d0 = dones;
      acc(0, `SDP_ADDR_DATA, 8'h0B);
      wait_cnt(0, d0);
      `CHK("so", m ? 8'hD0 : 8'h0B, i_sdp_peer.rx_sh)
      acc(1, `SDP_ADDR_DATA, 8'h00);
      `CHK("si", m ? 8'h48 : 8'h12, rv)
    end
    acc(0, `SDP_ADDR_SYNC_CTRL, 8'h83);
    `CHK("idle lo", 1'b0, sck)
    // slave select high holds the transfer back
    ss_n = 1'b1;
    acc(0, `SDP_ADDR_SYNC_CTRL, 8'hC2);
    i_sdp_peer.load(8'h00);
    d0 = dones;
    acc(0, `SDP_ADDR_DATA, 8'h5A);
    repeat (200) @(posedge clk);
    #1;
    `CHK("ss hold", d0, dones)
    `CHK("ss sck", 1'b1, sck)
    ss_n = 1'b0;
    wait_cnt(0, d0);
    `CHK("ss so", 8'h5A, i_sdp_peer.rx_sh)
    acc(0, `SDP_ADDR_SYNC_CTRL, 8'h00);
    results;
  end
endmodule // sdp_top_tb_top
`default_nettype wire
